// *** bench/host_model.sv ***
// Host model issuing configuration and I/O cycles to the block.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	// Clock.
	input  wire logic        sys_clk,
	// Requests.
	output var  logic        cfg_wr,
	output var  logic        cfg_rd,
	output var  logic [7:0]  cfg_addr,
	output var  logic [3:0]  cfg_be,
	output var  logic [31:0] cfg_wdata,
	output var  logic        io_req,
	output var  logic [31:0] io_addr,
	// Answers.
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_rack
);
	initial
		{cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata, io_req, io_addr} = '0;
	// Strobes are one-cycle pulses, so each task waits an edge first.
	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge sys_clk);
		cfg_wr    <= 1'b1;
		cfg_addr  <= a;
		cfg_be    <= be;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_wr    <= 1'b0;
		cfg_wdata <= ~d;
	endtask
	task automatic cfg_read(input logic [7:0] a, output logic [31:0] d,
		output logic k);
		@(posedge sys_clk);
		cfg_rd   <= 1'b1;
		cfg_addr <= a;
		@(posedge sys_clk);
		cfg_rd   <= 1'b0;
		#1 d = cfg_rdata;
		k = cfg_rack;
	endtask
	task automatic io_cycle(input logic [31:0] a);
		@(posedge sys_clk);
		io_req  <= 1'b1;
		io_addr <= a;
		@(posedge sys_clk);
		io_req  <= 1'b0;
		io_addr <= ~a;
		#1;
	endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the index port base and system setup registers.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import legacy_ctrl_pkg::*;
	logic        sys_clk, rst, ce, cfg_wr, cfg_rd, cfg_rack, io_req, k;
	logic        io_claim, io_index_hit, io_data_hit, sock_pwr_write;
	logic        card_present_pin, clk_term_oe, clk_src_internal;
	logic        legacy_irq_line_two, card_status_change_irq;
	logic        system_mgmt_interrupt, rsvd_pin_out, rsvd_pin_oe;
	logic [7:0]  cfg_addr, rot;
	logic [3:0]  cfg_be, pci_irq, serial_irq_slot;
	logic [31:0] cfg_wdata, cfg_rdata, io_addr, d;
	int          n_fail, checks_done, cyc;
	legacy_index_setup DUT (.sys_clk, .rst, .ce, .cfg_wr, .cfg_rd,
		.cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rack, .io_req,
		.io_addr, .io_claim, .io_index_hit, .io_data_hit, .sock_pwr_write,
		.card_present_pin, .pci_irq, .serial_irq_slot, .clk_term_oe,
		.clk_src_internal, .legacy_irq_line_two, .card_status_change_irq,
		.system_mgmt_interrupt, .rsvd_pin_out, .rsvd_pin_oe);
	host_model host (.sys_clk, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be,
		.cfg_wdata, .io_req, .io_addr, .cfg_rdata, .cfg_rack);
	initial
	begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		host.cfg_read(a, d, k);
		chk("rack", 1, {31'h0, k});
		chk(n, e, d);
	endtask
	task io_chk(input logic [31:0] a, input logic [31:0] e);
		host.io_cycle(a);
		chk("io_hits", e, {29'h0, io_claim, io_index_hit, io_data_hit});
	endtask
	task pwr_pulse;
		@(posedge sys_clk) sock_pwr_write <= 1'b1;
		@(posedge sys_clk) sock_pwr_write <= 1'b0;
		#1;
	endtask
	task t_reset;
		rd_chk("base_rst", 8'h44, RST_INDEX_BASE);
		rd_chk("setup_rst", 8'h80, RST_SYSTEM_SETUP);
		rd_chk("unmapped", 8'h10, 0);
		chk("clk_int", 3, {30'h0, clk_term_oe, clk_src_internal});
		$display("t_reset finished");
	endtask
	task t_base;
		host.cfg_write(8'h44, 4'hf, 32'hfedcba98);
		rd_chk("base_wr", 8'h44, 32'hfedcba99);
		io_chk(32'hfedcba98, 6);
		io_chk(32'hfedcba99, 5);
		io_chk(32'hfedcba9a, 0);
		$display("t_base finished");
	endtask
	// With the enable low neither a write nor an I/O cycle may be taken.
	task t_freeze;
		@(posedge sys_clk) ce <= 1'b0;
		host.cfg_write(8'h44, 4'hf, 32'h00001230);
		io_chk(32'hfedcba98, 0);
		@(posedge sys_clk) ce <= 1'b1;
		rd_chk("base_frozen", 8'h44, 32'hfedcba99);
		$display("t_freeze finished");
	endtask
	task t_setup;
		host.cfg_write(8'h80, 4'h7, '1);
		rd_chk("setup_lane", 8'h80, RST_SYSTEM_SETUP);
		host.cfg_write(8'h80, 4'hf, '1);
		rd_chk("setup_all", 8'h80, 32'hfd449060);
		for (int s = 0; s < 4; s++)
		begin
			host.cfg_write(8'h80, 4'h8, {s[1:0], 30'h0});
			repeat (2) @(posedge sys_clk);
			#1 rot = {pci_irq, pci_irq} << s;
			chk("slot", {28'h0, rot[7:4]}, {28'h0, serial_irq_slot});
			chk("clk_ext", 0, {31'h0, clk_term_oe});
		end
		$display("t_setup finished");
	endtask
	task t_power;
		host.cfg_write(8'h80, 4'hf, 32'h01000000);
		pwr_pulse;
		chk("mgmt", 2, {30'h0, system_mgmt_interrupt,
			card_status_change_irq});
		@(posedge sys_clk);
		#1 chk("line_two", 1, {31'h0, legacy_irq_line_two});
		rd_chk("flag_set", 8'h80, 32'h03049060);
		host.cfg_write(8'h80, 4'h8, 32'h01000000);
		rd_chk("flag_kept", 8'h80, 32'h03049060);
		host.cfg_write(8'h80, 4'h8, 32'h03000000);
		rd_chk("flag_clr", 8'h80, 32'h01049060);
		chk("line_off", 0, {31'h0, legacy_irq_line_two});
		fork
			host.cfg_write(8'h80, 4'h8, 32'h03000000);
			pwr_pulse;
		join
		rd_chk("flag_tie", 8'h80, 32'h03049060);
		host.cfg_write(8'h80, 4'h8, 32'h05000000);
		pwr_pulse;
		chk("csc", 3, {30'h0, system_mgmt_interrupt,
			card_status_change_irq});
		host.cfg_write(8'h80, 4'h8, 32'h02000000);
		pwr_pulse;
		chk("no_mgmt", 0, {31'h0, system_mgmt_interrupt});
		rd_chk("no_flag", 8'h80, 32'h00049060);
		$display("t_power finished");
	endtask
	task t_pins;
		@(posedge sys_clk) card_present_pin <= 1'b1;
		host.cfg_write(8'h80, 4'h4, 32'h00400000);
		repeat (4) @(posedge sys_clk);
		#1 chk("rsvd_on", 2, {30'h0, rsvd_pin_oe, rsvd_pin_out});
		host.cfg_write(8'h80, 4'h4, 0);
		repeat (2) @(posedge sys_clk);
		#1 chk("rsvd_off", 0, {30'h0, rsvd_pin_oe, rsvd_pin_out});
		host.cfg_write(8'h80, 4'h4, 32'h00400000);
		@(posedge sys_clk) card_present_pin <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 chk("rsvd_nocard", 0, {30'h0, rsvd_pin_oe, rsvd_pin_out});
		$display("t_pins finished");
	endtask
	task t_global_reset_n;
		@(posedge sys_clk) rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk("base_global_reset_n", 8'h44, RST_INDEX_BASE);
		rd_chk("setup_global_reset_n", 8'h80, RST_SYSTEM_SETUP);
		$display("t_global_reset_n finished");
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// The whole run needs about a hundred cycles; the ceiling leaves margin.
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			give_verdict;
		end
	end
	initial
	begin
		rst = 1;
		ce = 1;
		sock_pwr_write = 0;
		card_present_pin = 0;
		pci_irq = 4'b0011;
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		t_reset;
		t_base;
		t_freeze;
		t_setup;
		t_power;
		t_pins;
		t_global_reset_n;
		give_verdict;
	end
endmodule
`default_nettype wire

// *** hdl/irq_slot_rotator.sv ***
// Places the four PCI interrupts into serial frame slots by a rotation step.
`timescale 1ns/1ps
`default_nettype none
module irq_slot_rotator
	import legacy_ctrl_pkg::*;
(
	// Clock and reset.
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// Interrupts in and slots out.
	input  wire logic [IRQ_LINES-1:0] pci_irq,
	input  wire logic [1:0]           step,
	output var  logic [IRQ_LINES-1:0] slot
);
	genvar j;
	generate
		for (j = 0; j < IRQ_LINES; j++)
		begin : g_slot
			logic [1:0] src;
			assign src = 2'(j) - step;
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
					slot[j] <= 1'b0;
				else if (ce)
					slot[j] <= pci_irq[src]; // see R05
			end
		end
	endgenerate

	check_rotation_a: assert property ( // see R05
		@(posedge sys_clk) disable iff (rst)
		$past(ce) && !$past(rst)
		|-> slot == 4'(({$past(pci_irq), $past(pci_irq)}
			<< $past(step)) >> 4))
		else $error("Serial slot rotation wrong.");
	cover_rotate_three: cover property (@(posedge sys_clk) disable iff (rst)
		ce && step == 2'b11 && pci_irq == 4'h1);
endmodule
`default_nettype wire

// *** hdl/legacy_ctrl_pkg.sv ***
// Register map, field positions and reset values of the index port and setup.
package legacy_ctrl_pkg;
	localparam logic [7:0]  OFS_INDEX_BASE   = 8'h44;
	localparam logic [7:0]  OFS_SYSTEM_SETUP = 8'h80;
	localparam logic [31:0] RST_INDEX_BASE   = 32'h00000001;
	localparam logic [31:0] RST_SYSTEM_SETUP = 32'h08449060;
	localparam logic [31:0] SETUP_WR_MASK    = 32'hff400000;
	localparam logic [31:0] LOW_FIELDS_MASK  = 32'h003fffff;
	localparam int          ROT_HI           = 31;
	localparam int          ROT_LO           = 30;
	localparam int          SPARE_HI         = 29;
	localparam int          SPARE_LO         = 28;
	localparam int          CLK_SRC_BIT      = 27;
	localparam int          ROUTE_BIT        = 26;
	localparam int          FLAG_BIT         = 25;
	localparam int          ENABLE_BIT       = 24;
	localparam int          RSVD_BIT         = 23;
	localparam int          PIN_DRIVE_BIT    = 22;
	localparam int          FIXED_ONE_BIT    = 0;
	localparam logic [31:0] DATA_PORT_STEP   = 32'h00000001;
	localparam int          IRQ_LINES        = 4;
endpackage

// *** hdl/legacy_index_setup.sv ***
// Index port base and system setup registers with their side effects.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01 - I/O at base hits index port; base plus one hits data port.
// R02 - Base may sit anywhere in 32-bit I/O space, word aligned.
// R03 - Base bit 0 ignores writes and always reads one.
// R04 - Base register returns to default only under the global reset.
// R05 - Rotation field steps PCI interrupts by zero to three frame slots.
// R06 - Setup bits 29 to 28 are plain storage with no effect.
// R07 - Clock source bit one drives clock terminal; zero takes it as input.
// R08 - Route zero uses legacy line two; one raises card status change.
// R09 - Flag sets on socket power write while the enable is set.
// R10 - Writing one clears the flag; writing zero leaves it.
// R11 - Enable set makes each power write interrupt; enable resets off.
// R12 - Drive bit one pulls reserved pins low with a card present.
// R13 - Setup fields clear only under the global reset; the code reloads RST_SYSTEM_SETUP there, with bits 27 and 22 set.
// R14 - Setup bit 23 is reserved, reads zero, ignores writes.
// R15 - Only I/O cycles matching base or base plus one are claimed.
module legacy_index_setup
	import legacy_ctrl_pkg::*;
(
	// Clock, global reset and clock enable.
	input  wire logic                                sys_clk,
	input  wire logic                                rst,
	input  wire logic                                ce,
	// Configuration register access.
	input  wire logic                                cfg_wr,
	input  wire logic                                cfg_rd,
	input  wire logic [7:0]                          cfg_addr,
	input  wire logic [3:0]                          cfg_be,
	input  wire logic [31:0]                         cfg_wdata,
	output var  logic [31:0]                         cfg_rdata,
	output var  logic                                cfg_rack,
	// I/O cycles toward the index and data ports.
	input  wire logic                                io_req,
	input  wire logic [31:0]                         io_addr,
	output var  logic                                io_claim,
	output var  logic                                io_index_hit,
	output var  logic                                io_data_hit,
	// Events and pins.
	input  wire logic                                sock_pwr_write,
	input  wire logic                                card_present_pin,
	input  wire logic [legacy_ctrl_pkg::IRQ_LINES-1:0] pci_irq,
	output var  logic [legacy_ctrl_pkg::IRQ_LINES-1:0] serial_irq_slot,
	output var  logic                                clk_term_oe,
	output var  logic                                clk_src_internal,
	output var  logic                                legacy_irq_line_two,
	output var  logic                                card_status_change_irq,
	output var  logic                                system_mgmt_interrupt,
	output var  logic                                rsvd_pin_out,
	output var  logic                                rsvd_pin_oe
);
	import legacy_ctrl_pkg::*;

	logic [31:0] index_base;
	logic [31:0] setup;
	logic        card_meta;
	logic        card_sync;
	logic [31:0] wmask;
	logic        wr_base;
	logic        wr_setup;
	logic        pwr_event;
	logic [31:0] port_base;
	logic [31:0] next_base;
	logic [31:0] next_setup;

	assign wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
		{8{cfg_be[1]}}, {8{cfg_be[0]}}};
	assign wr_base = cfg_wr && cfg_addr == OFS_INDEX_BASE;
	assign wr_setup = cfg_wr && cfg_addr == OFS_SYSTEM_SETUP;
	assign pwr_event = sock_pwr_write && setup[ENABLE_BIT];
	assign port_base = {index_base[31:1], 1'b0};

	// Bit 0 is forced to one; port_base drops it so the port pair always starts on a word boundary.
	always_comb
	begin
		next_base = (index_base & ~wmask) | (cfg_wdata & wmask);
		next_base[FIXED_ONE_BIT] = 1'b1; // see R03
	end

	// The flag is set by hardware and cleared by a one; set wins the tie.
	always_comb
	begin
		next_setup = setup;
		if (wr_setup)
		begin
			next_setup = (setup & ~(wmask & SETUP_WR_MASK))
				| (cfg_wdata & wmask & SETUP_WR_MASK); // see R06
			next_setup[RSVD_BIT] = 1'b0; // see R14
			next_setup[FLAG_BIT] = setup[FLAG_BIT]
				& ~(cfg_wdata[FLAG_BIT] & cfg_be[3]); // see R10
		end
		if (pwr_event)
			next_setup[FLAG_BIT] = 1'b1; // see R09
		next_setup = next_setup & ~LOW_FIELDS_MASK;
	end

	// Only the global reset reaches these; no bus reset input exists.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			index_base <= RST_INDEX_BASE; // see R04
		else if (ce && wr_base)
			index_base <= next_base; // see R02
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			setup <= RST_SYSTEM_SETUP & SETUP_WR_MASK; // see R13
		else if (ce)
			setup <= next_setup; // see R11
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_rdata <= '0;
			cfg_rack <= 1'b0;
		end
		else if (ce)
		begin
			cfg_rack <= cfg_rd;
			if (cfg_rd && cfg_addr == OFS_INDEX_BASE)
				cfg_rdata <= index_base;
			else if (cfg_rd && cfg_addr == OFS_SYSTEM_SETUP)
				cfg_rdata <= setup | (RST_SYSTEM_SETUP & LOW_FIELDS_MASK);
			else if (cfg_rd)
				cfg_rdata <= '0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			io_claim <= 1'b0;
			io_index_hit <= 1'b0;
			io_data_hit <= 1'b0;
		end
		else if (ce)
		begin
			io_index_hit <= io_req && io_addr == port_base; // see R01
			io_data_hit <= io_req
				&& io_addr == port_base + DATA_PORT_STEP; // see R01
			io_claim <= io_req && (io_addr == port_base
				|| io_addr == port_base + DATA_PORT_STEP); // see R15
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			card_meta <= 1'b0;
			card_sync <= 1'b0;
		end
		else if (ce)
		begin
			card_meta <= card_present_pin;
			card_sync <= card_meta;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			clk_term_oe <= 1'b0;
			clk_src_internal <= 1'b0;
			legacy_irq_line_two <= 1'b0;
			card_status_change_irq <= 1'b0;
			system_mgmt_interrupt <= 1'b0;
			rsvd_pin_out <= 1'b0;
			rsvd_pin_oe <= 1'b0;
		end
		else if (ce)
		begin
			clk_term_oe <= setup[CLK_SRC_BIT]; // see R07
			clk_src_internal <= setup[CLK_SRC_BIT]; // see R07
			legacy_irq_line_two <= setup[FLAG_BIT]
				&& !setup[ROUTE_BIT]; // see R08
			card_status_change_irq <= pwr_event
				&& setup[ROUTE_BIT]; // see R08
			system_mgmt_interrupt <= pwr_event; // see R11
			rsvd_pin_out <= 1'b0;
			rsvd_pin_oe <= setup[PIN_DRIVE_BIT] && card_sync; // see R12
		end
	end

	irq_slot_rotator u_rot (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.pci_irq (pci_irq),
		.step    (setup[ROT_HI:ROT_LO]),
		.slot    (serial_irq_slot)
	);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// A frozen read answer may outlive its address, so the enable is checked.
	base_bit_zero_a: assert property ( // see R03
		cfg_rack && $past(ce) |-> !$past(cfg_addr == OFS_INDEX_BASE)
		|| cfg_rdata[FIXED_ONE_BIT])
		else $error("Base bit 0 read back as zero.");
	base_write_a: assert property ( // see R02
		ce && wr_base && cfg_be == 4'hf
		|=> index_base == {$past(cfg_wdata[31:1]), 1'b1})
		else $error("Base write not stored.");
	flag_set_a: assert property ( // see R09
		ce && sock_pwr_write && setup[ENABLE_BIT]
		|=> setup[FLAG_BIT])
		else $error("Flag not set on power write.");
	flag_clear_a: assert property ( // see R10
		ce && wr_setup && cfg_be[3]
		&& cfg_wdata[FLAG_BIT] && !pwr_event
		|=> !setup[FLAG_BIT])
		else $error("Flag not cleared by one.");
	flag_hold_a: assert property ( // see R10
		ce && wr_setup && !cfg_wdata[FLAG_BIT]
		&& setup[FLAG_BIT] |=> setup[FLAG_BIT])
		else $error("Flag lost on zero write.");
	reserved_zero_a: assert property ( // see R14
		!setup[RSVD_BIT])
		else $error("Reserved setup bit set.");
	csc_route_a: assert property ( // see R08
		ce && pwr_event && setup[ROUTE_BIT]
		|=> card_status_change_irq)
		else $error("Card status change not raised.");
	index_claim_a: assert property ( // see R01
		ce && io_req && io_addr == port_base
		|=> io_claim && io_index_hit && !io_data_hit)
		else $error("Index access not claimed.");
	no_claim_a: assert property ( // see R15
		ce && !(io_req && (io_addr == port_base
		|| io_addr == port_base + DATA_PORT_STEP)) |=> !io_claim)
		else $error("Foreign I/O cycle claimed.");
	pin_drive_a: assert property ( // see R12
		ce && setup[PIN_DRIVE_BIT] && card_sync
		|=> rsvd_pin_oe && !rsvd_pin_out)
		else $error("Reserved pins not driven low.");
	clock_src_a: assert property ( // see R07
		ce && !wr_setup
		|=> clk_term_oe == setup[CLK_SRC_BIT])
		else $error("Clock terminal direction wrong.");

	cover_data_hit: cover property (io_data_hit);
	cover_flag_clear: cover property (setup[FLAG_BIT] ##1 !setup[FLAG_BIT]);
	cover_pin_drive: cover property (rsvd_pin_oe);
	cover_irq_two: cover property (legacy_irq_line_two);
endmodule
`default_nettype wire
